// [src/tcp_pkg.sv]
// package for the touch controller serial register port
package tcp_pkg;

  // bus address of this target (7 bit), arbitrary default
  localparam logic [6:0] TARGET_ADDR = 7'h48;
  // register index width and count
  localparam int REG_AW = 4;
  localparam int REG_NUM = 16;
  // control byte 0 layout: [7:4] register index, [3] read bit
  localparam int CB_IDX_MSB = 7;
  localparam int CB_IDX_LSB = 4;
  localparam int CB_RD_BIT = 3;
  // software reset register index and its trigger bit
  localparam logic [3:0] SWRST_IDX = 4'h0;
  localparam int SWRST_BIT = 15;
  // configuration register index and notify-select bit
  localparam logic [3:0] CFG_IDX = 4'h1;
  localparam int NSEL_BIT = 0;
  // status register index, result register index
  localparam logic [3:0] STAT_IDX = 4'h2;
  localparam logic [3:0] RES_IDX = 4'h3;
  // status layout
  localparam int STAT_RDY_BIT = 1;
  localparam int STAT_TCH_BIT = 0;
  // reset pin low time and its cycle count at 40 MHz
  localparam int RST_LOW_US = 10;
  localparam int CLK_MHZ = 40;
  localparam int RST_LOW_CYC = RST_LOW_US * CLK_MHZ;
  // notify pin meaning
  typedef enum logic {TCP_NOTE_READY, TCP_NOTE_TOUCH} tcp_note_e;
  // data line drive pair
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
  } tcp_sda_s;
  // bus protocol phases
  typedef enum logic [2:0] {
    TCP_IDLE, TCP_ADDR, TCP_AACK, TCP_WRX, TCP_WACK, TCP_RTX, TCP_RACK
  } tcp_state_e;
endpackage

// [src/tcp_port.sv]
// serial register port of the touch controller, bus target side
`timescale 1ns/1ps
// Functional notes
// RULE1 - device is target only; host clocks
// RULE2 - host writes registers as byte pairs
// RULE3 - control byte 0 sets read pointer
// RULE4 - reads stream from pointed register onward
// RULE5 - read pointer kept across transactions
// RULE6 - software or pin reset clears pointer
// RULE7 - results readable any time, no handshake
// RULE8 - notify pin selects ready or touch
// RULE9 - ready mode shows conversion finished
// RULE10 - touch mode shows touch detected
// RULE11 - status shows both ready and touch
// RULE12 - reset pin held low 10 us
// RULE13 - ack address and bytes, release after send
module tcp_port #(
  parameter int RST_CYC = tcp_pkg::RST_LOW_CYC // reset pin low cycles to accept a reset
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_pin_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic touch_detect_irq,
  output logic notify_out_pin,
  output logic notify_sel,
  output logic soft_reset
);

  //////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    logic scl_d;                 // previous scl
    logic sda_d;                 // previous sda
    tcp_pkg::tcp_state_e st;     // protocol phase
    logic [7:0] shf;             // shift register
    logic [3:0] bcnt;            // bits moved in the current byte
    logic rw;                    // 1 = host reads
    logic hack;                  // host acknowledge seen in a read ack slot, low = more
    logic [1:0] wph;             // write byte phase: 0 ctrl, 1 hi, 2 lo
    logic [3:0] widx;            // write target index
    logic [7:0] whi;             // held high data byte
    logic ptr_ok;                // pointer valid
    logic [3:0] ptr;             // stored read pointer, kept across transactions
    logic [3:0] rcur;            // read cursor, reloaded from ptr per transaction
    logic rhalf;                 // 0 high byte, 1 low byte next
    tcp_pkg::tcp_note_e nsel;    // notify meaning
    logic rdy;                   // result ready flag
    logic [15:0] res;            // latched result
    tcp_pkg::tcp_sda_s sda;      // data line drive, open drain
    logic notify;                // notify pin value
    logic srst;                  // one-cycle software reset pulse
    logic [15:0] rcnt;           // reset pin low counter
  } tcp_st_s;

  tcp_st_s s_reg;
  tcp_st_s s_next;

  //////////////////////////////////////////////////////////////////////////////
  // read data mux; unmapped indices read zero
  function automatic logic [15:0] rd_word(input tcp_st_s s, input logic [3:0] i);
    logic [15:0] w;
    w = 16'h0000;
    if (i == tcp_pkg::CFG_IDX) begin
      w[tcp_pkg::NSEL_BIT] = s.nsel;
    end else if (i == tcp_pkg::STAT_IDX) begin
      w[tcp_pkg::STAT_RDY_BIT] = s.rdy; // RULE11
      w[tcp_pkg::STAT_TCH_BIT] = touch_detect_irq; // RULE11
    end else if (i == tcp_pkg::RES_IDX) begin
      w = s.res; // RULE7
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic; host clock edges are found against the delayed copies
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic load;
    logic pin_rst;
    logic [15:0] w;
    logic [15:0] wd;
    logic [7:0] b;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    load = 1'b0;
    pin_rst = 1'b0;
    w = 16'h0000;
    wd = 16'h0000;
    b = 8'h00;
    s_next = s_reg;
    s_next.scl_d = scl_in;
    s_next.sda_d = sda_in;
    s_next.srst = 1'b0;
    // open drain: the line is only ever pulled low
    s_next.sda.sda_out = 1'b0;
    rise = scl_in & ~s_reg.scl_d;
    fall = ~scl_in & s_reg.scl_d;
    start = scl_in & s_reg.scl_d & s_reg.sda_d & ~sda_in;
    stop = scl_in & s_reg.scl_d & ~s_reg.sda_d & sda_in;
    // word under the read cursor and the byte of it that goes out next
    w = rd_word(s_reg, s_reg.rcur);
    wd = {s_reg.whi, s_reg.shf};
    if (!s_reg.ptr_ok) begin
      b = 8'hFF; // no pointer: the line stays released
    end else if (s_reg.rhalf) begin
      b = w[7:0];
    end else begin
      b = w[15:8];
    end
    // host drives the clock; the target only follows edges
    if (start) begin // RULE1
      s_next.st = tcp_pkg::TCP_ADDR;
      s_next.bcnt = 4'd0;
      s_next.sda.sda_oe = 1'b0;
      s_next.wph = 2'd0;
    end else if (stop) begin
      s_next.st = tcp_pkg::TCP_IDLE;
      s_next.sda.sda_oe = 1'b0;
    end else begin
      case (s_reg.st)
        tcp_pkg::TCP_IDLE: begin
          s_next.sda.sda_oe = 1'b0;
        end
        tcp_pkg::TCP_ADDR: begin
          // address byte in on rising edges, decided on the eighth falling edge
          if (rise) begin
            s_next.shf = {s_reg.shf[6:0], sda_in};
            s_next.bcnt = s_reg.bcnt + 4'd1;
          end
          if (fall && s_reg.bcnt == 4'd8) begin
            if (s_reg.shf[7:1] == tcp_pkg::TARGET_ADDR) begin
              s_next.sda.sda_oe = 1'b1; // RULE13
              s_next.rw = s_reg.shf[0];
              s_next.st = tcp_pkg::TCP_AACK;
              if (s_reg.shf[0]) begin
                s_next.rcur = s_reg.ptr; // RULE5
                s_next.rhalf = 1'b0;
              end
            end else begin
              s_next.st = tcp_pkg::TCP_IDLE; // not ours: leave the line alone
            end
          end
        end
        tcp_pkg::TCP_AACK: begin
          if (fall) begin
            if (s_reg.rw) begin
              load = 1'b1; // RULE4
            end else begin
              s_next.sda.sda_oe = 1'b0;
              s_next.bcnt = 4'd0;
              s_next.st = tcp_pkg::TCP_WRX;
            end
          end
        end
        tcp_pkg::TCP_WRX: begin
          if (rise) begin
            s_next.shf = {s_reg.shf[6:0], sda_in};
            s_next.bcnt = s_reg.bcnt + 4'd1;
          end
          if (fall && s_reg.bcnt == 4'd8) begin
            s_next.sda.sda_oe = 1'b1; // RULE13
            s_next.st = tcp_pkg::TCP_WACK;
            if (s_reg.wph == 2'd0) begin
              if (s_reg.shf[tcp_pkg::CB_RD_BIT]) begin
                // control byte with read bit: only the pointer moves
                s_next.ptr = s_reg.shf[tcp_pkg::CB_IDX_MSB:tcp_pkg::CB_IDX_LSB]; // RULE5
                s_next.ptr_ok = 1'b1; // RULE5
              end else begin
                s_next.widx = s_reg.shf[tcp_pkg::CB_IDX_MSB:tcp_pkg::CB_IDX_LSB];
                s_next.wph = 2'd1;
              end
            end else if (s_reg.wph == 2'd1) begin
              s_next.whi = s_reg.shf;
              s_next.wph = 2'd2;
            end else begin
              // second data byte: the register word is complete
              s_next.wph = 2'd0;
              if (s_reg.widx == tcp_pkg::CFG_IDX) begin
                s_next.nsel = tcp_pkg::tcp_note_e'(wd[tcp_pkg::NSEL_BIT]); // RULE8
              end
              if (s_reg.widx == tcp_pkg::SWRST_IDX && wd[tcp_pkg::SWRST_BIT]) begin
                s_next.ptr_ok = 1'b0; // RULE6
                s_next.nsel = tcp_pkg::TCP_NOTE_READY;
                s_next.rdy = 1'b0;
                s_next.srst = 1'b1;
              end
            end
          end
        end
        tcp_pkg::TCP_WACK: begin
          if (fall) begin
            s_next.sda.sda_oe = 1'b0; // RULE13
            s_next.bcnt = 4'd0;
            s_next.st = tcp_pkg::TCP_WRX;
          end
        end
        tcp_pkg::TCP_RTX: begin
          // next bit goes out just after each falling edge
          if (fall) begin
            if (s_reg.bcnt == 4'd8) begin
              s_next.sda.sda_oe = 1'b0; // RULE13
              s_next.st = tcp_pkg::TCP_RACK;
            end else begin
              s_next.sda.sda_oe = ~s_reg.shf[7];
              s_next.shf = {s_reg.shf[6:0], 1'b0};
              s_next.bcnt = s_reg.bcnt + 4'd1;
            end
          end
        end
        tcp_pkg::TCP_RACK: begin
          if (rise) begin
            s_next.hack = sda_in;
          end
          if (fall) begin
            if (!s_reg.hack) begin
              load = 1'b1; // RULE4
            end else begin
              s_next.st = tcp_pkg::TCP_IDLE; // host ended the read
            end
          end
        end
        default: begin
          s_next.st = tcp_pkg::TCP_IDLE;
          s_next.sda.sda_oe = 1'b0;
        end
      endcase
    end
    // start a read byte: first bit out now, cursor steps as the low byte is loaded
    if (load) begin
      s_next.sda.sda_oe = ~b[7];
      s_next.shf = {b[6:0], 1'b0};
      s_next.bcnt = 4'd1;
      s_next.st = tcp_pkg::TCP_RTX;
      s_next.rhalf = ~s_reg.rhalf;
      if (s_reg.rhalf) begin
        s_next.rcur = s_reg.rcur + 4'h1; // RULE4
      end
      if (s_reg.ptr_ok && s_reg.rhalf && s_reg.rcur == tcp_pkg::RES_IDX) begin
        s_next.rdy = 1'b0; // low result byte loaded for sending
      end
    end
    // reset pin low time counted; only a long enough low resets
    if (!rst_pin_n) begin
      if (s_reg.rcnt != 16'(RST_CYC)) begin
        s_next.rcnt = s_reg.rcnt + 16'h0001;
      end
    end else begin
      s_next.rcnt = 16'h0000;
    end
    pin_rst = !rst_pin_n && (s_reg.rcnt == 16'(RST_CYC - 1));
    if (pin_rst) begin
      s_next.ptr_ok = 1'b0; // RULE6
      s_next.nsel = tcp_pkg::TCP_NOTE_READY;
      s_next.rdy = 1'b0;
      s_next.st = tcp_pkg::TCP_IDLE;
      s_next.sda.sda_oe = 1'b0;
    end
    // result capture last, so a fresh result wins over any clear
    if (conv_done) begin
      s_next.res = conv_result; // RULE7
      s_next.rdy = 1'b1; // RULE9
    end
    // notify pin carries whichever meaning is selected
    if (s_next.nsel == tcp_pkg::TCP_NOTE_TOUCH) begin
      s_next.notify = touch_detect_irq; // RULE10
    end else begin
      s_next.notify = s_next.rdy; // RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; idle bus levels on reset so no false start follows
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign sda_out = s_reg.sda.sda_out;
  assign sda_oe = s_reg.sda.sda_oe;
  assign notify_out_pin = s_reg.notify;
  assign notify_sel = s_reg.nsel;
  assign soft_reset = s_reg.srst;

  // the low counter is 16 bits wide and needs at least two counts
  if (RST_CYC < 2 || RST_CYC > 65535) begin : g_bad_rst
    $error("RST_CYC out of range");
  end

endmodule

// [test/tcp_port_props.sv]
// checker for the touch port bus pins and notify output
`timescale 1ns/1ps
module tcp_port_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_pin_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire logic touch_detect_irq,
  input wire logic notify_out_pin,
  input wire logic notify_sel,
  input wire logic soft_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // consecutive low cycles seen on the reset pin, saturating
  int lowcnt;
  always_ff @(posedge clk_sys) begin
    if (rst || rst_pin_n) lowcnt <= 0;
    else if (lowcnt < tcp_pkg::RST_LOW_CYC) lowcnt <= lowcnt + 1;
  end
  // open drain: only ever pull low
  property p_od; sda_oe |-> !sda_out; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_pin; lowcnt == tcp_pkg::RST_LOW_CYC |-> !sda_oe && !notify_sel; endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_soft; soft_reset |-> ##[1:3] !notify_sel; endproperty
  a_soft: assert property (p_soft) else $error("soft reset ignored");
  property p_tch; notify_sel && touch_detect_irq |-> ##[0:3] notify_out_pin; endproperty
  a_tch: assert property (p_tch) else $error("touch not shown");
  property p_rdy; !notify_sel && conv_done |-> ##[0:3] notify_out_pin; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not shown");
  // a stop leaves the line released
  property p_stop; scl_in && $rose(sda_in) |=> !sda_oe [*3]; endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
  // the target may only start pulling the line low while the clock is low
  property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
  a_rise: assert property (p_rise) else $error("drive while scl high");
endmodule

// [test/tcp_host_model.sv]
// bus controller model that clocks the touch port
`timescale 1ns/1ps
module tcp_host_model (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // four system cycles per wait step (clock low two steps, high one), slow enough for input sync
  task automatic w;
    repeat (4) @(posedge clk_sys);
  endtask
  // start or repeated start, host owns the clock
  task automatic start;
    w;
    sda_drv <= 1'b1;
    w;
    scl <= 1'b1;
    w;
    sda_drv <= 1'b0;
    w;
    scl <= 1'b0;
  endtask
  task automatic stop;
    w;
    sda_drv <= 1'b0;
    w;
    scl <= 1'b1;
    w;
    sda_drv <= 1'b1;
    w;
  endtask
  // data moves one wait step after the clock falls
  task automatic bit_x(input logic d, output logic q);
    w;
    sda_drv <= d;
    w;
    scl <= 1'b1;
    w;
    q = sda_wire;
    scl <= 1'b0;
  endtask
  // eight bits msb first then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(mack, ack);
  endtask
endmodule

// [test/tcp_port_tb_top.sv]
// testbench for the touch port with a bus controller model
`timescale 1ns/1ps
module tcp_port_tb_top;
  logic clk_sys, rst, rst_pin_n, conv_done, touch_detect_irq, scl_in, sda_drv;
  logic sda_out, sda_oe, notify_out_pin, notify_sel, soft_reset, ack;
  logic [15:0] conv_result;
  logic [7:0] q;
  logic [6:0] adr = tcp_pkg::TARGET_ADDR;
  int bad_count, comparisons, cyc;
  // pull-up bus: low when either party pulls
  wire sda_in = sda_drv & ~(sda_oe & ~sda_out);
  tcp_port uut (.clk_sys(clk_sys), .rst(rst), .rst_pin_n(rst_pin_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
    .conv_result(conv_result), .touch_detect_irq(touch_detect_irq),
    .notify_out_pin(notify_out_pin), .notify_sel(notify_sel), .soft_reset(soft_reset));
  tcp_host_model host (.clk_sys(clk_sys), .sda_wire(sda_in), .scl(scl_in), .sda_drv(sda_drv));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    host.xfer(b, 1'b1, q, ack);
    check(ack, 8'h00);
  endtask
  // another address must be left unanswered
  task automatic t_addr;
    host.start;
    host.xfer({adr ^ 7'h01, 1'b0}, 1'b1, q, ack);
    check(ack, 8'h01);
    host.stop;
  endtask
  // point at result, read two bytes, then read again without pointing
  task automatic t_read;
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    host.start;
    wr({adr, 1'b0});
    wr(8'h38);
    host.start;
    wr({adr, 1'b1});
    host.xfer(8'hFF, 1'b0, q, ack);
    check(q, 8'hA5);
    host.xfer(8'hFF, 1'b1, q, ack);
    check(q, 8'hC3);
    host.stop;
    host.start;
    wr({adr, 1'b1});
    host.xfer(8'hFF, 1'b1, q, ack);
    check(q, 8'hA5);
    host.stop;
  endtask
  // select touch, pin reset, then config plus soft reset in one go
  task automatic t_cfg;
    host.start;
    wr({adr, 1'b0});
    wr(8'h10);
    wr(8'h00);
    wr(8'h01);
    host.stop;
    check(notify_sel, 8'h01);
    touch_detect_irq <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(notify_out_pin, 8'h01);
    rst_pin_n <= 1'b0;
    repeat (tcp_pkg::RST_LOW_CYC) @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    check(notify_sel, 8'h00);
    repeat (2) @(posedge clk_sys);
    check(notify_out_pin, 8'h01);
    host.start;
    wr({adr, 1'b0});
    wr(8'h10);
    wr(8'h00);
    wr(8'h01);
    wr(8'h00);
    wr(8'h80);
    wr(8'h00);
    host.stop;
    check(notify_sel, 8'h00);
    host.start;
    wr({adr, 1'b1});
    host.xfer(8'hFF, 1'b1, q, ack);
    check(q, 8'hFF);
    host.stop;
    host.start;
    wr({adr, 1'b0});
    wr(8'h28);
    host.start;
    wr({adr, 1'b1});
    host.xfer(8'hFF, 1'b0, q, ack);
    check(q, 8'h00);
    host.xfer(8'hFF, 1'b1, q, ack);
    check(q, 8'h01);
    host.stop;
  endtask
  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b1;
    conv_done = 1'b0;
    touch_detect_irq = 1'b0;
    conv_result = 16'hA5C3;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_addr;
    t_read;
    t_cfg;
    summarize;
  end
endmodule
bind tcp_port tcp_port_props chk (.*);
